// ### hw/cvs_char_video.sv
// Character video serializer: pattern memory, dot serializer, attributes.
// Assumes codes, line select and strobes are synchronous to core_clk_i.
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module cvs_char_video #(
  parameter int unsigned BLINK_CYCLES = cvs_pkg::BLINK_CYCLES
) (
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  // Avalon-MM register slave.
  input  wire logic [12:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Character and line select from the refresh buffer and timing logic.
  input  wire logic [7:0]  char_code_i,
  input  wire logic        line_sel_b0_i,
  input  wire logic        line_sel_b1_i,
  input  wire logic        line_sel_b2_i,
  input  wire logic        upper_lines_flag_i,
  input  wire logic        attr_load_strobe_i,
  input  wire logic        attr_clear_strobe_i,
  // Cursor inputs.
  input  wire logic [2:0]  cursor_status_bits_n_i,
  input  wire logic        cursor_match_i,
  input  wire logic        cursor_scan_line_i,
  // Timing and video toward the mixer.
  output logic             char_rate_clock_o,
  output logic             video_o,
  output logic             dim_o,
  output logic             blank_o,
  output logic             cursor_o
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic [16:0] ph_acc;
    logic        ph_fall;
    logic [2:0]  dot_cnt;
    logic        char_clk;
    logic        load_ctl;
    logic        half_shift;
    logic [6:0]  pat;
    logic [6:0]  sreg;
    logic        video_q;
    logic [2:0]  attr;
    logic [24:0] blink_cnt;
    logic        ctrl_en;
    logic        waitreq;
    logic [31:0] rdata;
    logic        video;
    logic        dim;
    logic        blank;
    logic        cursor;
  } cvs_state_type;

  cvs_state_type r;
  cvs_state_type next_r;

  logic [7:0]  pat_mem [0:cvs_pkg::PAT_ENTRIES-1];
  logic [9:0]  rom_addr;
  logic        rom_lo_en;
  logic        rom_hi_en;
  logic [7:0]  rom_dout;
  logic        lines_zero;
  logic        ext_load_inhibit_n;
  logic        load_clear;
  logic        rise_tick;
  logic        shift_tick;
  logic        bus_req;
  logic        pat_hit;
  logic [16:0] acc_sum;

  ////////////////////////////////////////////////////////////////////////////

  // Both memories share one array; the enables only gate the read, and the code bits in the address pick the entry.
  assign rom_addr  = {char_code_i[6:0], line_sel_b2_i, line_sel_b1_i,
                      line_sel_b0_i};
  assign rom_lo_en = !char_code_i[7] && (char_code_i[5] == char_code_i[6]);
  assign rom_hi_en = !char_code_i[7] && (char_code_i[5] != char_code_i[6]);
  // Attribute commands enable neither memory, so they draw no glyph.
  assign rom_dout  = (rom_lo_en || rom_hi_en) ? pat_mem[rom_addr]
                                              : cvs_pkg::PAT_NONE;

  assign lines_zero = !line_sel_b0_i && !line_sel_b1_i && !line_sel_b2_i;
  assign ext_load_inhibit_n = 1'h1;
  // Line zero of a descender, or line eight of anything else, is not loaded.
  assign load_clear = !ext_load_inhibit_n ||
                      (lines_zero && upper_lines_flag_i && !rom_dout[7]) ||
                      (lines_zero && !upper_lines_flag_i && rom_dout[7]);

  assign acc_sum    = r.ph_acc + cvs_pkg::HALF_STEP;
  assign rise_tick  = (acc_sum >= cvs_pkg::ACC_MOD) && !r.ph_fall;
  // A set half flag moves the serializer onto the opposite dot clock phase.
  assign shift_tick = (acc_sum >= cvs_pkg::ACC_MOD) && (r.ph_fall == r.half_shift);

  assign bus_req = (avs_read_i || avs_write_i) && r.waitreq;
  assign pat_hit = avs_address_i[12];

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_r = r;

    // Half-dot ticks from a phase accumulator; the dot rate is not a divisor.
    if (acc_sum >= cvs_pkg::ACC_MOD) begin
      next_r.ph_acc  = acc_sum - cvs_pkg::ACC_MOD;
      next_r.ph_fall = !r.ph_fall;
    end else begin
      next_r.ph_acc = acc_sum;
    end

    if (rise_tick) begin
      next_r.dot_cnt  = r.dot_cnt + 3'h1;
      next_r.char_clk = (r.dot_cnt >= 3'h7) || (r.dot_cnt < 3'h3);
      next_r.video_q  = r.sreg[6];
      if (r.dot_cnt == 3'h7) begin
        next_r.pat        = rom_dout[6:0];
        next_r.load_ctl   = !load_clear;
        next_r.half_shift = !rom_dout[7];
      end
    end

    // One load per cell, then six shifts, or seven with the half flag set, fill the remaining dots.
    if (shift_tick && !(rise_tick && r.dot_cnt == 3'h7)) begin
      if (r.load_ctl) begin
        next_r.sreg     = r.pat;
        next_r.load_ctl = 1'h0;
      end else begin
        next_r.sreg = {r.sreg[5:0], 1'h0};
      end
    end

    // The clear strobe marks line end and wins over a load.
    if (attr_clear_strobe_i) begin
      next_r.attr = cvs_pkg::ATTR_NORMAL;
    end else if (attr_load_strobe_i) begin
      next_r.attr = char_code_i[2:0];
    end

    if (r.blink_cnt >= 25'(BLINK_CYCLES - 1)) begin
      next_r.blink_cnt = 25'h0;
    end else begin
      next_r.blink_cnt = r.blink_cnt + 25'h1;
    end

    next_r.video = r.video_q;
    case (r.attr)
      cvs_pkg::ATTR_BLINK, cvs_pkg::ATTR_BLINK_REV: begin
        if (r.blink_cnt >= 25'(BLINK_CYCLES / 4 * 3)) begin
          next_r.video = 1'h0;
        end
      end
      default: begin
      end
    endcase
    if (r.attr[0] && r.attr != cvs_pkg::ATTR_OFF) begin
      next_r.video = !next_r.video;
    end
    if (r.attr == cvs_pkg::ATTR_UNDERLINE && cursor_scan_line_i) begin
      next_r.video = 1'h1;
    end
    next_r.blank = (r.attr == cvs_pkg::ATTR_OFF) || !r.ctrl_en;
    if (next_r.blank) begin
      next_r.video = 1'h0;
    end
    next_r.dim = (r.attr == cvs_pkg::ATTR_DIM) || (r.attr == cvs_pkg::ATTR_DIM_REV);
    // The cursor toggles at the blink rate so reverse video cannot hide it.
    next_r.cursor = cursor_match_i &&
                    ((!cursor_status_bits_n_i[1] && cursor_scan_line_i) ||
                     !cursor_status_bits_n_i[0]) &&
                    (r.blink_cnt < 25'(BLINK_CYCLES / 2));

    // One wait state per access; the answer stands at the low edge.
    next_r.waitreq = 1'h1;
    if (bus_req) begin
      next_r.waitreq = 1'h0;
      next_r.rdata   = 32'h0;
      if (avs_read_i) begin
        if (pat_hit) begin
          next_r.rdata = {24'h0, pat_mem[avs_address_i[11:2]]};
        end else if (avs_address_i == cvs_pkg::CTRL_ADDR) begin
          next_r.rdata[cvs_pkg::CTRL_EN_BIT] = r.ctrl_en;
        end else if (avs_address_i == cvs_pkg::STATUS_ADDR) begin
          next_r.rdata[2:0] = r.attr;
          next_r.rdata[cvs_pkg::STAT_HALF_BIT] = r.half_shift;
          next_r.rdata[cvs_pkg::STAT_LOAD_BIT] = r.load_ctl;
        end
      end
    end
    if (avs_write_i && !r.waitreq && avs_address_i == cvs_pkg::CTRL_ADDR) begin
      next_r.ctrl_en = avs_writedata_i[cvs_pkg::CTRL_EN_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r         <= '0;
      r.waitreq <= 1'h1;
      r.ctrl_en <= cvs_pkg::CTRL_RESET;
      r.blank   <= 1'h1;
    end else begin
      r <= next_r;
    end
  end

  // Pattern memory has no reset; software loads the glyphs before display.
  always_ff @(posedge core_clk_i) begin
    if (avs_write_i && !r.waitreq && pat_hit) begin
      pat_mem[avs_address_i[11:2]] <= avs_writedata_i[7:0];
    end
  end

  assign avs_readdata_o    = r.rdata;
  assign avs_waitrequest_o = r.waitreq;
  assign char_rate_clock_o = r.char_clk;
  assign video_o           = r.video;
  assign dim_o             = r.dim;
  assign blank_o           = r.blank;
  assign cursor_o          = r.cursor;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_load_release;
    r.load_ctl && shift_tick && !(rise_tick && r.dot_cnt == 3'h7) |=> !r.load_ctl;
  endproperty
  a_load_release: assert property (p_load_release) else $error("load held");

  property p_attr_none;
    char_code_i[7:5] == cvs_pkg::ATTR_CMD_TOP |-> rom_dout == cvs_pkg::PAT_NONE;
  endproperty
  a_attr_none: assert property (p_attr_none) else $error("attr drawn");

  property p_rom_lo;
    !char_code_i[7] && char_code_i[5] == char_code_i[6] |-> rom_lo_en && !rom_hi_en;
  endproperty
  a_rom_lo: assert property (p_rom_lo) else $error("rom select");

  property p_attr_clear;
    attr_clear_strobe_i |=> r.attr == cvs_pkg::ATTR_NORMAL;
  endproperty
  a_attr_clear: assert property (p_attr_clear) else $error("attr clear");

  property p_attr_load;
    attr_load_strobe_i && !attr_clear_strobe_i |=> r.attr == $past(char_code_i[2:0]);
  endproperty
  a_attr_load: assert property (p_attr_load) else $error("attr load");

  property p_desc_block;
    rise_tick && r.dot_cnt == 3'h7 && lines_zero && upper_lines_flag_i && !rom_dout[7]
      |=> !r.load_ctl ##1 !r.load_ctl;
  endproperty
  a_desc_block: assert property (p_desc_block) else $error("line0 loaded");

  property p_l8_inhibit;
    rise_tick && r.dot_cnt == 3'h7 && lines_zero && !upper_lines_flag_i && rom_dout[7]
      |=> !r.load_ctl;
  endproperty
  a_l8_inhibit: assert property (p_l8_inhibit) else $error("line8 loaded");

  property p_half;
    rise_tick && r.dot_cnt == 3'h7 && !rom_dout[7] |=> r.half_shift;
  endproperty
  a_half: assert property (p_half) else $error("no half shift");

  property p_video_off;
    r.attr == cvs_pkg::ATTR_OFF |=> !r.video && r.blank;
  endproperty
  a_video_off: assert property (p_video_off) else $error("video not off");

  property p_underline;
    r.attr == cvs_pkg::ATTR_UNDERLINE && cursor_scan_line_i && r.ctrl_en |=> r.video;
  endproperty
  a_underline: assert property (p_underline) else $error("no underline");

  property p_rom_hi;
    !char_code_i[7] && char_code_i[5] != char_code_i[6] |-> rom_hi_en && !rom_lo_en;
  endproperty
  a_rom_hi: assert property (p_rom_hi) else $error("rom select high");

  property p_half_clear;
    rise_tick && r.dot_cnt == 3'h7 && rom_dout[7] |=> !r.half_shift;
  endproperty
  a_half_clear: assert property (p_half_clear) else $error("half shift held");

  // A lit dot under normal display must reach the mixer two clocks later.
  property p_resample;
    rise_tick && r.sreg[6] && r.attr == cvs_pkg::ATTR_NORMAL && r.ctrl_en &&
      !attr_load_strobe_i && !avs_write_i |=> ##1 r.video;
  endproperty
  a_resample: assert property (p_resample) else $error("dot not resampled");

  property p_blink_gap;
    r.attr == cvs_pkg::ATTR_BLINK &&
      r.blink_cnt >= 25'(BLINK_CYCLES / 4 * 3) |=> !r.video;
  endproperty
  a_blink_gap: assert property (p_blink_gap) else $error("blink not dark");

  property p_blink_rev;
    r.attr == cvs_pkg::ATTR_BLINK_REV && r.ctrl_en &&
      r.blink_cnt >= 25'(BLINK_CYCLES / 4 * 3) |=> r.video;
  endproperty
  a_blink_rev: assert property (p_blink_rev) else $error("blink reverse");

  property p_cursor_on;
    cursor_match_i && !cursor_status_bits_n_i[0] &&
      r.blink_cnt < 25'(BLINK_CYCLES / 2) |=> r.cursor;
  endproperty
  a_cursor_on: assert property (p_cursor_on) else $error("cursor missing");

  property p_cursor_off;
    !cursor_match_i |=> !r.cursor;
  endproperty
  a_cursor_off: assert property (p_cursor_off) else $error("cursor stray");

endmodule

`default_nettype wire

// ### hw/cvs_pkg.sv
// Constants shared by the character video serializer.
// Assumes a single 50 MHz core clock and an Avalon-MM register master.
package cvs_pkg;

  // Clock and dot rates, in kHz, and the clock again in MHz.
  localparam int CLK_KHZ  = 50000;
  localparam int DOT_KHZ  = 14976;
  localparam int CLK_MHZ  = CLK_KHZ / 1000;
  // Half-dot phase accumulator: two ticks per dot period.
  localparam logic [16:0] HALF_STEP = 17'(2 * DOT_KHZ);
  localparam logic [16:0] ACC_MOD   = 17'(CLK_KHZ);

  // Blink signal cycles 2.5 times per second: a 400 ms period.
  localparam int BLINK_PERIOD_US = 400000;
  localparam int BLINK_CYCLES    = BLINK_PERIOD_US * CLK_MHZ;

  // Cell layout and pattern memory geometry.
  localparam int DOTS_SHOWN = 7;
  localparam int PAT_ENTRIES = 1024;
  localparam logic [7:0] PAT_NONE = 8'h80;

  // Register map, byte addresses.
  localparam logic [12:0] CTRL_ADDR   = 13'h0000;
  localparam logic [12:0] STATUS_ADDR = 13'h0004;
  localparam logic [12:0] PAT_BASE    = 13'h1000;
  localparam int CTRL_EN_BIT      = 0;
  localparam logic CTRL_RESET     = 1'h1;
  localparam int STAT_HALF_BIT    = 3;
  localparam int STAT_LOAD_BIT    = 4;

  // Attribute codes.
  localparam logic [2:0] ATTR_NORMAL    = 3'h0;
  localparam logic [2:0] ATTR_OFF       = 3'h1;
  localparam logic [2:0] ATTR_UNDERLINE = 3'h2;
  localparam logic [2:0] ATTR_REVERSE   = 3'h3;
  localparam logic [2:0] ATTR_DIM       = 3'h4;
  localparam logic [2:0] ATTR_DIM_REV   = 3'h5;
  localparam logic [2:0] ATTR_BLINK     = 3'h6;
  localparam logic [2:0] ATTR_BLINK_REV = 3'h7;
  localparam logic [2:0] ATTR_CMD_TOP   = 3'h4;

endpackage

// ### tb/cvs_refresh_model.sv
// Refresh buffer and timing source feeding the character video serializer.
// Assumes the serializer's character-rate output marks each cell boundary.
`timescale 1ns/1ps
`default_nettype none

module cvs_refresh_model (
  // Clock and cell timing from the serializer.
  input  wire logic       core_clk_i,
  input  wire logic       char_rate_clock_i,
  // Code and scan line requested by the bench.
  input  wire logic [7:0] code_i,
  input  wire logic [3:0] line_i,
  // Drive toward the serializer.
  output logic      [7:0] char_code_o,
  output logic            line_sel_b0_o,
  output logic            line_sel_b1_o,
  output logic            line_sel_b2_o,
  output logic            upper_lines_flag_o
);
  logic rate_q;

  initial begin
    char_code_o = 8'h00;
    rate_q      = 1'b0;
  end

  // A code changes only just after a boundary, so it holds until the next sample.
  always @(posedge core_clk_i) begin
    rate_q <= char_rate_clock_i;
    if (char_rate_clock_i && !rate_q) begin
      char_code_o <= code_i;
    end
  end

  // Low select bits repeat on lines 0 and 8; the flag marks lines 0 to 7.
  assign line_sel_b0_o      = line_i[0];
  assign line_sel_b1_o      = line_i[1];
  assign line_sel_b2_o      = line_i[2];
  assign upper_lines_flag_o = ~line_i[3];
endmodule

`default_nettype wire

// ### tb/char_video_serializer_test.sv
// Self-checking bench for the character video serializer.
// Assumes the refresh model in its own file and a short blink period.
`timescale 1ns/1ps
`default_nettype none

module char_video_serializer_test;
  logic        core_clk_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [12:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [7:0]  char_code_i, code;
  logic [3:0]  line;
  logic        b0, b1, b2, up, rate, video_o, dim_o, blank_o, s;
  logic        attr_load_strobe_i, attr_clear_strobe_i, cursor_scan_line_i;
  logic        cursor_match_i, cursor_o;
  logic [2:0]  cursor_status_bits_n_i;
  int          err_count, tests_run, nz, nc;

  cvs_char_video #(.BLINK_CYCLES(64)) i_cvs_char_video (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .char_code_i(char_code_i), .line_sel_b0_i(b0), .line_sel_b1_i(b1), .line_sel_b2_i(b2),
    .upper_lines_flag_i(up), .attr_load_strobe_i(attr_load_strobe_i),
    .attr_clear_strobe_i(attr_clear_strobe_i),
    .cursor_status_bits_n_i(cursor_status_bits_n_i),
    .cursor_match_i(cursor_match_i), .cursor_scan_line_i(cursor_scan_line_i),
    .char_rate_clock_o(rate), .video_o(video_o), .dim_o(dim_o), .blank_o(blank_o),
    .cursor_o(cursor_o));

  cvs_refresh_model i_cvs_refresh_model (
    .core_clk_i(core_clk_i), .char_rate_clock_i(rate), .code_i(code), .line_i(line),
    .char_code_o(char_code_i), .line_sel_b0_o(b0), .line_sel_b1_o(b1),
    .line_sel_b2_o(b2), .upper_lines_flag_o(up));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One access; the request holds until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [12:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    avs_address_i   <= a;
    avs_read_i      <= ~wr;
    avs_write_i     <= wr;
    avs_writedata_i <= d;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    q = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
  endtask

  function automatic logic [12:0] pa(input logic [7:0] c, input logic [2:0] l);
    return cvs_pkg::PAT_BASE + 13'({c[6:0], l, 2'b00});
  endfunction

  // Shows a code for a few cells, then watches four whole blink periods of 64 clocks,
  // so dark and cursor cycle counts are exact whatever the blink phase.
  task automatic show(input logic [7:0] c, input logic [3:0] l);
    @(posedge core_clk_i);
    code <= c;
    line <= l;
    repeat (3) @(posedge rate);
    s  = 1'b0;
    nz = 0;
    nc = 0;
    repeat (256) begin
      @(posedge core_clk_i);
      s  = s | (video_o === 1'b1);
      nz += (video_o !== 1'b1);
      nc += (cursor_o === 1'b1);
    end
  endtask

  task automatic pulse(input logic ld, input logic clr);
    @(posedge core_clk_i);
    attr_load_strobe_i  <= ld;
    attr_clear_strobe_i <= clr;
    @(posedge core_clk_i);
    attr_load_strobe_i  <= 1'b0;
    attr_clear_strobe_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    bus(1'b0, cvs_pkg::STATUS_ADDR, 32'h0);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  // The whole run needs well under a third of this span.
  initial begin
    repeat (60000) @(posedge core_clk_i);
    err_count++;
    tally_and_finish;
  end

  initial begin
    {rstn_i, avs_read_i, avs_write_i, attr_load_strobe_i, attr_clear_strobe_i} = 5'h00;
    {avs_address_i, avs_writedata_i, code, line, cursor_scan_line_i} = 58'h0;
    {cursor_match_i, cursor_status_bits_n_i} = 4'h7;
    err_count = 0;
    tests_run = 0;
    repeat (16) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    bus(1'b0, cvs_pkg::CTRL_ADDR, 32'h0);
    chk("ctrl reset", 32'h1, q);
    bus(1'b1, 13'h0008, 32'h5A);
    bus(1'b0, 13'h0008, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b0, cvs_pkg::STATUS_ADDR, 32'h0);
    chk("attr reset", 32'h0, q[2:0]);
    bus(1'b1, pa(8'h41, 3'h0), 32'hFF);
    bus(1'b1, pa(8'h41, 3'h3), 32'hFF);
    bus(1'b1, pa(8'h67, 3'h0), 32'h7F);
    bus(1'b1, pa(8'h67, 3'h3), 32'h7F);
    bus(1'b0, pa(8'h41, 3'h3), 32'h0);
    chk("pattern", 32'hFF, q);
    show(8'h41, 4'h3);
    chk("upper video", 32'h1, s);
    chk("upper dark", 32'h0, nz);
    chk("no cursor", 32'h0, nc);
    show(8'h41, 4'h0);
    chk("upper line0", 32'h1, s);
    show(8'h41, 4'h8);
    chk("upper line8", 32'h0, s);
    show(8'h67, 4'h0);
    chk("desc line0", 32'h0, s);
    show(8'h67, 4'h8);
    chk("desc line8", 32'h1, s);
    show(8'h67, 4'h3);
    chk("lower video", 32'h1, s);
    bus(1'b0, cvs_pkg::STATUS_ADDR, 32'h0);
    chk("half set", 32'h1, q[3]);
    show(8'h41, 4'h3);
    bus(1'b0, cvs_pkg::STATUS_ADDR, 32'h0);
    chk("half clear", 32'h0, q[3]);
    show(8'hC1, 4'h3);
    chk("high code", 32'h0, s);
    show(8'h81, 4'h3);
    chk("attr cmd", 32'h0, s);
    for (int v = 0; v < 8; v++) begin
      code <= 8'h80 | 8'(v);
      repeat (2) @(posedge rate);
      pulse(1'b1, 1'b0);
      cursor_scan_line_i <= (v == 2);
      show(8'h41, 4'h8);
      chk("attr video", (v[0] && v != 1) || v == 2, s);
      bus(1'b0, cvs_pkg::STATUS_ADDR, 32'h0);
      chk("attr", 32'(v), q[2:0]);
      chk("dim", v == 4 || v == 5, dim_o);
      chk("blank", v == 1, blank_o);
    end
    show(8'h41, 4'h3);
    chk("blink rev dark", 32'hC0, nz);
    code <= 8'h86;
    repeat (2) @(posedge rate);
    pulse(1'b1, 1'b0);
    show(8'h41, 4'h3);
    chk("blink dark", 32'h40, nz);
    cursor_scan_line_i <= 1'b0;
    pulse(1'b0, 1'b1);
    chk("attr clear", 32'h0, q[2:0]);
    code <= 8'h87;
    repeat (2) @(posedge rate);
    pulse(1'b1, 1'b1);
    chk("clear wins", 32'h0, q[2:0]);
    cursor_match_i         <= 1'b1;
    cursor_status_bits_n_i <= 3'h6;
    show(8'h41, 4'h3);
    chk("block cursor", 32'h80, nc);
    cursor_status_bits_n_i <= 3'h5;
    show(8'h41, 4'h3);
    chk("underline off", 32'h0, nc);
    cursor_scan_line_i <= 1'b1;
    show(8'h41, 4'h3);
    chk("underline cursor", 32'h80, nc);
    bus(1'b1, cvs_pkg::CTRL_ADDR, 32'h0);
    repeat (2) @(posedge core_clk_i);
    chk("disabled", 32'h1, blank_o);
    bus(1'b1, cvs_pkg::CTRL_ADDR, 32'h1);
    repeat (2) @(posedge core_clk_i);
    chk("enabled", 32'h0, blank_o);
    tally_and_finish;
  end
endmodule

`default_nettype wire
